// ### pkg/pwmsds_defines.vh
// Register offsets, field positions, reset values and timing for the PWM output stage
`ifndef PWMSDS_DEFINES_VH
`define PWMSDS_DEFINES_VH

`define PWMSDS_ADDR_W 2
`define PWMSDS_OFF_SHUTDOWN 2'h0
`define PWMSDS_OFF_RESTART_DB 2'h1
`define PWMSDS_OFF_STEERING 2'h2
`define PWMSDS_OFF_MODE 2'h3

`define PWMSDS_RST_SHUTDOWN 8'h00
`define PWMSDS_RST_RESTART_DB 8'h00
`define PWMSDS_RST_STEERING 5'h01
`define PWMSDS_RST_MODE 6'h00

`define PWMSDS_BIT_EVENT 7
`define PWMSDS_BIT_RESTART 7
`define PWMSDS_BIT_SYNC 4

`define PWMSDS_SRC_C1 3'h1
`define PWMSDS_SRC_C2 3'h2
`define PWMSDS_SRC_PIN 3'h4

`define PWMSDS_SS_LOW 2'h0
`define PWMSDS_SS_HIGH 2'h1

`define PWMSDS_MODE_PWM 2'h3
`define PWMSDS_BRIDGE_SINGLE 2'h0
`define PWMSDS_BRIDGE_HALF 2'h2

// One instruction cycle is four oscillator periods
`define PWMSDS_OSC_PER_INSTR 2'h3

`endif

// ### rtl/pwmsds_output_stage.v
// PWM output stage: auto-shutdown, dead-band delay and pulse steering
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "pwmsds_defines.vh"

module pwmsds_output_stage (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register port
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    // Waveform from the period and duty generator
    input wire pwm_raw,
    input wire period_start,
    // Shutdown sources
    input wire comp1_out,
    input wire comp2_out,
    input wire comp2_out_synced,
    input wire comp2_sync_enable,
    input wire ext_int_pin,
    // Output pins
    output reg pwm_out_a_q,
    output reg pwm_out_b_q,
    output reg pwm_out_c_q,
    output reg pwm_out_d_q,
    output reg [3:0] pwm_out_oe_q,
    output reg [3:0] pwm_steer_own_q
);

    localparam ST_RUN = 2'h0;
    localparam ST_SHUT = 2'h1;
    localparam ST_WAIT = 2'h2;

    // Input synchronisers, second stage only is read
    reg [2:0] meta_q;
    reg [2:0] sync_q;
    reg comp1_s;
    reg comp2_s;
    reg pin_s;

    reg [7:0] shutdown_q;
    reg [7:0] restart_db_q;
    reg [4:0] steering_q;
    reg [3:0] steer_live_q;
    reg [5:0] mode_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [1:0] div_q;
    reg instr_tick_q;
    reg [6:0] db_cnt_a_q;
    reg [6:0] db_cnt_b_q;
    reg act_a_q;
    reg act_b_q;
    reg raw_a_q;
    reg raw_b_q;

    wire [2:0] src_sel;
    wire cond;
    wire shutting;
    wire wr_shutdown;
    wire wr_restart;
    wire wr_steering;
    wire wr_mode;
    wire steer_mode;
    wire half_mode;
    wire pol_ac;
    wire pol_bd;
    reg [3:0] lvl;
    reg [3:0] en;
    reg [7:0] rdata_d;
    wire [3:0] pol;
    wire [3:0] pin_d;
    wire [3:0] oe_d;
    wire [3:0] shut_lvl;
    wire [3:0] shut_oe;
    wire comp2_pick;

    always @(posedge clk) begin
        if (!reset_n) begin
            // Idle levels: pin high, comparators low, so no false trigger
            meta_q <= 3'h4;
            sync_q <= 3'h4;
        end else begin
            meta_q <= {ext_int_pin, comp2_pick, comp1_out};
            sync_q <= meta_q;
        end
    end

    // Synced path adds the Timer1 latency ahead of our own stages
    assign comp2_pick = comp2_sync_enable ? comp2_out_synced : comp2_out;

    always @* begin
        comp1_s = sync_q[0];
        comp2_s = sync_q[1];
        pin_s = ~sync_q[2];
    end

    assign src_sel = shutdown_q[6:4];
    // Level-based: present for as long as any selected source holds
    assign cond = (src_sel[0] & comp1_s) | (src_sel[1] & comp2_s)
        | (src_sel[2] & pin_s);
    assign wr_shutdown = reg_wr && (reg_addr == `PWMSDS_OFF_SHUTDOWN);
    assign wr_restart = reg_wr && (reg_addr == `PWMSDS_OFF_RESTART_DB);
    assign wr_steering = reg_wr && (reg_addr == `PWMSDS_OFF_STEERING);
    assign wr_mode = reg_wr && (reg_addr == `PWMSDS_OFF_MODE);

    // Instruction-cycle tick from the core clock
    // Registered tick keeps the divider compare off the enable path
    always @(posedge clk) begin
        if (!reset_n) begin
            div_q <= 2'h0;
            instr_tick_q <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            instr_tick_q <= (div_q == `PWMSDS_OSC_PER_INSTR);
        end
    end

    // Shutdown sequencing
    always @* begin
        state_d = state_q;
        case (state_q)
            // Running: a selected trigger or a software set
            ST_RUN: begin
                if (cond || (wr_shutdown && reg_wdata[`PWMSDS_BIT_EVENT])) begin
                    state_d = ST_SHUT;
                end
            end
            // Held: the flag may drop only once the trigger is gone
            ST_SHUT: begin
                if (!cond && restart_db_q[`PWMSDS_BIT_RESTART]) begin
                    state_d = ST_WAIT;
                end else if (!cond && wr_shutdown && !reg_wdata[`PWMSDS_BIT_EVENT]) begin
                    state_d = ST_WAIT;
                end
            end
            // Flag clear but pins stay forced until a period edge
            ST_WAIT: begin
                if (cond || (wr_shutdown && reg_wdata[`PWMSDS_BIT_EVENT])) begin
                    state_d = ST_SHUT;
                end else if (period_start) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // Pins stay forced until the period restarts, flag clears as soon as allowed
    // Trigger bypasses the state register so pins follow one cycle sooner
    assign shutting = (state_q != ST_RUN) || cond;

    always @(posedge clk) begin
        if (!reset_n) begin
            state_q <= ST_RUN;
            shutdown_q <= `PWMSDS_RST_SHUTDOWN;
            restart_db_q <= `PWMSDS_RST_RESTART_DB;
            steering_q <= `PWMSDS_RST_STEERING;
            mode_q <= `PWMSDS_RST_MODE;
        end else begin
            state_q <= state_d;
            // Flag follows the state; a write to bit 7 only steers the state
            if (wr_shutdown) begin
                shutdown_q[6:0] <= reg_wdata[6:0];
            end
            // Flag reads 1 while held; a trigger beats a clear, but an auto-restart clear beats a software set
            shutdown_q[`PWMSDS_BIT_EVENT] <= (state_d == ST_SHUT);
            if (wr_restart) begin
                restart_db_q <= reg_wdata;
            end
            if (wr_steering) begin
                steering_q <= reg_wdata[4:0];
            end
            if (wr_mode) begin
                mode_q <= reg_wdata[5:0];
            end
        end
    end

    // Mode register: [5:4] bridge config, [3:2] mode upper, [1:0] polarity
    assign steer_mode = (mode_q[3:2] == `PWMSDS_MODE_PWM)
        && (mode_q[5:4] == `PWMSDS_BRIDGE_SINGLE);
    assign half_mode = (mode_q[3:2] == `PWMSDS_MODE_PWM)
        && (mode_q[5:4] == `PWMSDS_BRIDGE_HALF);
    assign pol_ac = mode_q[1];
    assign pol_bd = mode_q[0];
    // Steering applies the A/C polarity to every pin
    assign pol[0] = pol_ac;
    assign pol[1] = steer_mode ? pol_ac : pol_bd;
    assign pol[2] = pol_ac;
    assign pol[3] = steer_mode ? pol_ac : pol_bd;

    // Steering enables take effect on period or instruction boundary
    // Immediate mode may cut a pulse short; period mode never does
    always @(posedge clk) begin
        if (!reset_n) begin
            steer_live_q <= 4'h1;
        end else if (steering_q[`PWMSDS_BIT_SYNC] ? period_start : instr_tick_q) begin
            steer_live_q <= steering_q[3:0];
        end
    end

    // Dead-band: delay rising edge of each half-bridge output by count instruction cycles
    // Counter restarts on every fall, so a short pulse never activates
    always @(posedge clk) begin
        if (!reset_n) begin
            raw_a_q <= 1'b0;
            raw_b_q <= 1'b0;
            act_a_q <= 1'b0;
            act_b_q <= 1'b0;
            db_cnt_a_q <= 7'h00;
            db_cnt_b_q <= 7'h00;
        end else begin
            raw_a_q <= pwm_raw;
            raw_b_q <= ~pwm_raw;
            if (!pwm_raw) begin
                act_a_q <= 1'b0;
                db_cnt_a_q <= 7'h00;
            end else if (db_cnt_a_q >= restart_db_q[6:0]) begin
                act_a_q <= 1'b1;
            end else if (instr_tick_q) begin
                db_cnt_a_q <= db_cnt_a_q + 7'h01;
            end
            if (pwm_raw) begin
                act_b_q <= 1'b0;
                db_cnt_b_q <= 7'h00;
            end else if (db_cnt_b_q >= restart_db_q[6:0]) begin
                act_b_q <= 1'b1;
            end else if (instr_tick_q) begin
                db_cnt_b_q <= db_cnt_b_q + 7'h01;
            end
        end
    end

    // Active levels per pin before polarity; dead-band only in half-bridge
    // C and D carry the undelayed A and B levels outside steering
    always @* begin
        if (steer_mode) begin
            lvl = {4{raw_a_q}};
        end else if (half_mode) begin
            lvl = {raw_b_q, raw_a_q, act_b_q, act_a_q};
        end else begin
            lvl = {raw_b_q, raw_a_q, raw_b_q, raw_a_q};
        end
    end

    // Single mode without any steer bit shows nothing on any pin
    always @* begin
        if (steer_mode) begin
            en = steer_live_q;
        end else if (half_mode) begin
            // Half-bridge drives only A and B
            en = 4'h3;
        end else begin
            en = 4'h0;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_shut
            // Pins A,C use the AC field, B,D the BD field
            wire [1:0] ss;
            assign ss = (i % 2 == 0) ? shutdown_q[3:2] : shutdown_q[1:0];
            assign shut_lvl[i] = (ss == `PWMSDS_SS_HIGH);
            // A set upper bit releases the pin rather than driving it
            assign shut_oe[i] = ~ss[1];
            assign pin_d[i] = shutting ? shut_lvl[i] : (lvl[i] ^ pol[i]);
            assign oe_d[i] = en[i] & (~shutting | shut_oe[i]);
        end
    endgenerate

    // Registered pin drive; forcing applies only to enabled pins
    always @(posedge clk) begin
        if (!reset_n) begin
            pwm_out_a_q <= 1'b0;
            pwm_out_b_q <= 1'b0;
            pwm_out_c_q <= 1'b0;
            pwm_out_d_q <= 1'b0;
            pwm_out_oe_q <= 4'h0;
            pwm_steer_own_q <= 4'h0;
        end else begin
            pwm_steer_own_q <= en;
            pwm_out_a_q <= pin_d[0];
            pwm_out_b_q <= pin_d[1];
            pwm_out_c_q <= pin_d[2];
            pwm_out_d_q <= pin_d[3];
            pwm_out_oe_q <= oe_d;
        end
    end

    // Register read, data in the cycle after the strobe; idle reads as zero
    always @* begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `PWMSDS_OFF_SHUTDOWN) begin
                rdata_d = shutdown_q;
            end else if (reg_addr == `PWMSDS_OFF_RESTART_DB) begin
                rdata_d = restart_db_q;
            end else if (reg_addr == `PWMSDS_OFF_STEERING) begin
                rdata_d = {3'h0, steering_q};
            end else begin
                rdata_d = {2'h0, mode_q};
            end
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end

endmodule // pwmsds_output_stage

// ### bench/pwmsds_switch_model.sv
// Power switch driver model that sees the four output pins
`timescale 1ns/100ps
module pwmsds_switch_model (
    // Pins from the stage
    input wire clk,
    input wire [3:0] pin,
    input wire [3:0] oe,
    // Levels the drivers see
    output reg [3:0] level
);
    integer i;
    // No pull resistor: a released pin reads inverted, never as driven
    // Only pins the host has made outputs reach the switch
    always @(posedge clk) begin
        for (i = 0; i < 4; i = i + 1) begin
            level[i] <= oe[i] ? pin[i] : ~pin[i];
        end
    end
endmodule // pwmsds_switch_model

// ### bench/pwmsds_output_stage_assertions.sv
// Port assertions for the PWM output stage
`timescale 1ns/100ps
module pwmsds_output_stage_assertions (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register port
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    // Source and pins
    input wire ext_int_pin,
    input wire pwm_out_a_q,
    input wire [3:0] pwm_out_oe_q,
    input wire [3:0] pwm_steer_own_q
);
    reg [7:0] sd_q;
    reg [4:0] st_q;
    reg [5:0] md_q;
    reg [3:0] lo_q;
    reg rb_q;
    wire pin_shut = sd_q[6] && lo_q > 4'h6;
    always @(posedge clk) begin
        if (!reset_n) begin
            sd_q <= 8'h00;
            st_q <= 5'h01;
            md_q <= 6'h00;
            lo_q <= 4'h0;
            rb_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 2'h1) rb_q <= reg_wdata[7];
            if (reg_wr && reg_addr == 2'h0) sd_q <= reg_wdata;
            if (reg_wr && reg_addr == 2'h2) st_q <= reg_wdata[4:0];
            if (reg_wr && reg_addr == 2'h3) md_q <= reg_wdata[5:0];
            lo_q <= ext_int_pin ? 4'h0 : (lo_q == 4'hF ? lo_q : lo_q + 4'h1);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata_q == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_str_pad; reg_rd && reg_addr == 2'h2 |=> reg_rdata_q[7:5] == 3'h0; endproperty
    a_str_pad: assert property (p_str_pad) else $error("steering pad bits set");
    property p_md_pad; reg_rd && reg_addr == 2'h3 |=> reg_rdata_q[7:6] == 2'h0; endproperty
    a_md_pad: assert property (p_md_pad) else $error("mode pad bits set");
    property p_flag; reg_rd && reg_addr == 2'h0 && pin_shut |=> reg_rdata_q[7]; endproperty
    a_flag: assert property (p_flag) else $error("flag low in shutdown");
    sequence s_force; reg_wr && reg_addr == 2'h0 && reg_wdata[7]; endsequence
    property p_force; reg_wr && reg_addr == 2'h0 && reg_wdata[7] && !rb_q ##1 !reg_wr
        ##1 (reg_rd && reg_addr == 2'h0) |=> reg_rdata_q[7]; endproperty
    a_force: assert property (p_force) else $error("forced flag missing");
    property p_ac_hi; pin_shut && sd_q[3:2] == 2'h1 && pwm_steer_own_q[0]
        |-> pwm_out_a_q && pwm_out_oe_q[0]; endproperty
    a_ac_hi: assert property (p_ac_hi) else $error("pin a not driven high");
    property p_bd_tri; pin_shut && sd_q[1] |-> !pwm_out_oe_q[1] && !pwm_out_oe_q[3]; endproperty
    a_bd_tri: assert property (p_bd_tri) else $error("pins b d not released");
    property p_own; (pwm_out_oe_q & ~pwm_steer_own_q) == 4'h0; endproperty
    a_own: assert property (p_own) else $error("port pin driven");
    property p_now; reg_wr && reg_addr == 2'h2 && !reg_wdata[4] && md_q[5:2] == 4'h3
        |-> ##[2:7] pwm_steer_own_q == st_q[3:0]; endproperty
    a_now: assert property (p_now) else $error("steering update late");
    property p_rst; !$past(reset_n) |-> pwm_out_oe_q == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("pins driven after reset");
    c_shut: cover property (pin_shut && reg_rd);
    c_force: cover property (s_force);
    c_steer: cover property (reg_wr && reg_addr == 2'h2 && md_q[5:2] == 4'h3);
endmodule // pwmsds_output_stage_assertions
bind pwmsds_output_stage pwmsds_output_stage_assertions pwmsds_output_stage_assertions_i (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .ext_int_pin, .pwm_out_a_q, .pwm_out_oe_q, .pwm_steer_own_q);

// ### bench/pwmsds_output_stage_tb_top.sv
// Register-level testbench for the PWM output stage
`timescale 1ns/100ps
`include "pwmsds_defines.vh"
module pwmsds_output_stage_tb_top;
    reg clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, pwm_raw = 0, period_start = 0;
    reg comp1_out = 0, comp2_out = 0, comp2_out_synced = 0;
    reg comp2_sync_enable = 0, ext_int_pin = 1;
    reg [1:0] reg_addr = 0;
    reg [7:0] reg_wdata = 0;
    wire [7:0] reg_rdata_q;
    wire pwm_out_a_q, pwm_out_b_q, pwm_out_c_q, pwm_out_d_q;
    wire [3:0] pwm_out_oe_q, pwm_steer_own_q, level;
    integer fail_count = 0, n_tests = 0, s, k;
    pwmsds_output_stage pwmsds_output_stage_i (.clk, .reset_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_q, .pwm_raw, .period_start, .comp1_out, .comp2_out,
        .comp2_out_synced, .comp2_sync_enable, .ext_int_pin, .pwm_out_a_q,
        .pwm_out_b_q, .pwm_out_c_q, .pwm_out_d_q, .pwm_out_oe_q, .pwm_steer_own_q);
    pwmsds_switch_model pwmsds_switch_model_i (.clk, .oe(pwm_out_oe_q), .level,
        .pin({pwm_out_d_q, pwm_out_c_q, pwm_out_b_q, pwm_out_a_q}));
    initial forever #2 clk = ~clk;
    task chk(input [7:0] seen, input [7:0] exp, input [8*5:1] nm);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected %0s: expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task wr(input [1:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [1:0] a, input [7:0] e, input [8*5:1] nm);
        begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata_q, e, nm);
        end
    endtask
    task per;
        begin
            @(posedge clk) period_start <= 1'b1;
            @(posedge clk) period_start <= 1'b0;
            cyc(4);
        end
    endtask
    task complete_run;
        begin
            if (fail_count == 0 && n_tests > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(0, `PWMSDS_RST_SHUTDOWN, "sdc");
        rd(1, `PWMSDS_RST_RESTART_DB, "rdb");
        rd(2, {3'h0, `PWMSDS_RST_STEERING}, "str");
        rd(3, {2'h0, `PWMSDS_RST_MODE}, "mode");
        wr(3, 8'hFF);
        rd(3, 8'h3F, "mode");
        wr(3, 8'h0C);
        wr(2, 8'hF5);
        rd(2, 8'h15, "str");
        wr(2, 8'h05);
        @(posedge clk) pwm_raw <= 1'b1;
        cyc(8);
        chk({pwm_steer_own_q, pwm_out_oe_q}, 8'h55, "own");
        chk({pwm_out_a_q, pwm_out_c_q}, 2'h3, "pins");
        @(posedge clk) pwm_raw <= 1'b0;
        wr(0, 8'h46);
        @(posedge clk) ext_int_pin <= 1'b0;
        cyc(8);
        chk({pwm_out_a_q, pwm_out_c_q, level[0], pwm_out_oe_q}, 7'h75, "shut");
        rd(0, 8'hC6, "flag");
        wr(0, 8'h46);
        rd(0, 8'hC6, "flag");
        @(posedge clk) ext_int_pin <= 1'b1;
        cyc(8);
        rd(0, 8'hC6, "flag");
        wr(0, 8'h46);
        rd(0, 8'h46, "flag");
        chk(pwm_out_a_q, 1'b1, "hold");
        per;
        chk(pwm_out_a_q, 1'b0, "run");
        wr(0, 8'h86);
        rd(0, 8'h86, "force");
        cyc(3);
        chk(pwm_out_a_q, 1'b1, "force");
        wr(0, 8'h06);
        per;
        wr(1, 8'h80);
        for (s = 0; s < 8; s = s + 1) begin
            for (k = 0; k < 3; k = k + 1) begin
                wr(0, {1'b0, s[2:0], 4'h6});
                @(posedge clk) {ext_int_pin, comp2_out, comp1_out} <= {k != 2, k == 1, k == 0};
                cyc(8);
                rd(0, {s[k], s[2:0], 4'h6}, "src");
                @(posedge clk) {ext_int_pin, comp2_out, comp1_out} <= 3'h4;
                cyc(8);
                rd(0, {1'b0, s[2:0], 4'h6}, "auto");
                per;
            end
        end
        // Five ticks of dead band is twenty clocks before a may rise
        wr(1, 8'h05);
        wr(3, 8'h2C);
        per;
        @(posedge clk) pwm_raw <= 1'b1;
        cyc(12);
        chk(pwm_out_a_q, 1'b0, "dead");
        cyc(16);
        chk(pwm_out_a_q, 1'b1, "live");
        @(posedge clk) pwm_raw <= 1'b0;
        cyc(3);
        chk(pwm_out_a_q, 1'b0, "fall");
        chk(pwm_out_b_q, 1'b0, "bdead");
        cyc(28);
        chk(pwm_out_b_q, 1'b1, "blive");
        wr(3, 8'h0E);
        wr(2, 8'h0F);
        cyc(8);
        chk({pwm_steer_own_q, pwm_out_d_q, pwm_out_c_q, pwm_out_b_q, pwm_out_a_q},
            8'hFF, "all");
        wr(0, 8'h26);
        @(posedge clk) {comp2_sync_enable, comp2_out} <= 2'h3;
        cyc(8);
        rd(0, 8'h26, "csync");
        @(posedge clk) comp2_out_synced <= 1'b1;
        cyc(8);
        rd(0, 8'hA6, "csync");
        chk(pwm_out_oe_q, 4'h5, "ctri");
        complete_run;
    end
endmodule // pwmsds_output_stage_tb_top
